// *** lsbm_defines.vh ***
`ifndef LSBM_DEFINES_VH
`define LSBM_DEFINES_VH
`define LSBM_INSTR_ALIGN_MASK 2'h0
`define LSBM_FMT_IMM 2'h0
`define LSBM_FMT_JUMP 2'h1
`define LSBM_FMT_REG 2'h2
`define LSBM_OP_SPECIAL 6'h00
`define LSBM_OP_REGIMM 6'h01
`define LSBM_OP_JUMP 6'h02
`define LSBM_OP_JUMP_LINK 6'h03
`define LSBM_OP_BEQ 6'h04
`define LSBM_OP_BNE 6'h05
`define LSBM_OP_BLEZ 6'h06
`define LSBM_OP_BGTZ 6'h07
`define LSBM_OP_BEQ_LIKELY 6'h14
`define LSBM_OP_BNE_LIKELY 6'h15
`define LSBM_OP_BLEZ_LIKELY 6'h16
`define LSBM_OP_BGTZ_LIKELY 6'h17
`define LSBM_OP_SPECIAL2 6'h1C
`define LSBM_OP_LOAD_LINKED 6'h30
`define LSBM_OP_STORE_COND 6'h38
`define LSBM_FN_REG_JUMP 6'h08
`define LSBM_FN_REG_JUMP_LINK 6'h09
`define LSBM_FN_READ_HIGH 6'h10
`define LSBM_FN_READ_LOW 6'h12
`define LSBM_FN_MULT 6'h18
`define LSBM_FN_MULTU 6'h19
`define LSBM_FN_DIV 6'h1A
`define LSBM_FN_UNSIGNED_DIVIDE 6'h1B
`define LSBM_FN2_MADD 6'h00
`define LSBM_FN2_MADDU 6'h01
`define LSBM_FN2_MUL_GPR 6'h02
`define LSBM_FN2_MSUB 6'h04
`define LSBM_FN2_MSUBU 6'h05
`define LSBM_FN2_CLZ 6'h20
`define LSBM_FN2_CLO 6'h21
`define LSBM_LINK_REG 5'h1F
`define LSBM_SIZE_WORD 2'h3
`define LSBM_SIZE_TRIPLE 2'h2
`define LSBM_SIZE_HALF 2'h1
`define LSBM_SIZE_BYTE 2'h0
`define LSBM_MD_NONE 3'h0
`define LSBM_MD_ACC 3'h1
`define LSBM_MD_GPR 3'h2
`define LSBM_MD_DIV 3'h3
`define LSBM_MD_READ 3'h4
`define LSBM_MD_COUNT 3'h5
`define LSBM_LAT_SHORT 6'h03
`define LSBM_LAT_LONG 6'h04
`define LSBM_REP_SHORT 6'h02
`define LSBM_REP_LONG 6'h03
`define LSBM_STALL_SHORT 6'h01
`define LSBM_STALL_LONG 6'h02
`define LSBM_DIV_CYCLES 6'h24
`define LSBM_LOAD_USE_WAIT 6'h01
`endif

// *** lsbm_core.v ***
// Operation
// [RULE1] one aligned 32-bit word per instruction
// [RULE2] decode immediate, jump and register layouts
// [RULE3] address is base plus signed 16-bit offset
// [RULE4] interlock dependent instruction right after load
// [RULE5] address names lowest-order byte always
// [RULE6] size codes word3 triple2 half1 byte0
// [RULE7] misaligned size/address raises address error
// [RULE8] lowest byte is msb lane when big-endian
// [RULE9] product reads wait for muldiv completion
// [RULE10] multiply latency 3/4, reissue 2/3
// [RULE11] multiply to register also stalls 1/2
// [RULE12] divide latency and reissue 36 cycles
// [RULE13] leading count single cycle, no stall
// [RULE14] one delay slot after every transfer
// [RULE15] jump target is pc top plus target
// [RULE16] register jump takes register contents
// [RULE17] branch target is slot plus offset
// [RULE18] untaken likely branch nullifies delay slot
// [RULE19] linking transfers write return address
`include "lsbm_defines.vh"
module lsbm_core (
  input wire i_mclk,
  input wire i_srst,
  input wire i_instr_valid,
  input wire [31:0] i_instr,
  input wire [31:0] i_pc,
  input wire [31:0] i_rs_val,
  input wire [31:0] i_rt_val,
  input wire i_big_endian,
  output reg o_ready,
  output reg o_exec,
  output reg [31:0] o_exec_pc,
  output reg [1:0] o_format,
  output reg o_fetch_err,
  output reg o_nullified,
  output reg o_mem_valid,
  output reg o_mem_store,
  output reg [31:0] o_mem_addr,
  output reg [1:0] o_mem_size,
  output reg [3:0] o_mem_lanes,
  output reg o_addr_err,
  output reg o_redirect,
  output reg [31:0] o_target,
  output reg o_link_we,
  output reg [4:0] o_link_reg,
  output reg [31:0] o_link_data,
  output reg o_md_start,
  output reg o_hilo_read,
  output reg o_hilo_sel_high,
  output reg o_count_valid,
  output reg [5:0] o_count_value
);

  function [1:0] f_format;
    input [31:0] w;
    begin
      if (w[31:26] == `LSBM_OP_SPECIAL || w[31:26] == `LSBM_OP_SPECIAL2) begin
        f_format = `LSBM_FMT_REG;
      end else if (w[31:26] == `LSBM_OP_JUMP || w[31:26] == `LSBM_OP_JUMP_LINK) begin
        f_format = `LSBM_FMT_JUMP;
      end else begin
        f_format = `LSBM_FMT_IMM;
      end
    end
  endfunction

  // loads 0x20-0x26 and 0x30, stores 0x28-0x2B, 0x2E and 0x38
  function f_is_load;
    input [31:0] w;
    begin
      f_is_load = (w[31:29] == 3'h4 && w[28:26] != 3'h7) || w[31:26] == `LSBM_OP_LOAD_LINKED;
    end
  endfunction

  function f_is_store;
    input [31:0] w;
    begin
      f_is_store = (w[31:29] == 3'h5 && w[28:27] != 2'h2 && w[28:26] != 3'h7) ||
                   w[31:26] == `LSBM_OP_STORE_COND;
    end
  endfunction

  function [1:0] f_size;
    input [31:0] w;
    begin
      if (w[31:26] == `LSBM_OP_LOAD_LINKED || w[31:26] == `LSBM_OP_STORE_COND) begin
        f_size = `LSBM_SIZE_WORD;
      end else begin
        case (w[27:26])
          2'h0: f_size = `LSBM_SIZE_BYTE;
          2'h1: f_size = `LSBM_SIZE_HALF;
          2'h2: f_size = `LSBM_SIZE_TRIPLE;
          default: f_size = `LSBM_SIZE_WORD;
        endcase
      end
    end
  endfunction

  function f_addr_ok;
    input [1:0] size;
    input [1:0] a;
    begin
      case (size)
        `LSBM_SIZE_WORD: f_addr_ok = (a == 2'h0);
        `LSBM_SIZE_TRIPLE: f_addr_ok = (a[1] == 1'b0);
        `LSBM_SIZE_HALF: f_addr_ok = (a[0] == 1'b0);
        default: f_addr_ok = 1'b1;
      endcase
    end
  endfunction

  // little-endian mask from the lowest byte upward; big-endian mirrors it
  function [3:0] f_lanes;
    input [1:0] size;
    input [1:0] a;
    input big;
    reg [3:0] m;
    begin
      m = 4'h0;
      case (size)
        `LSBM_SIZE_WORD: m = 4'hF;
        `LSBM_SIZE_TRIPLE: m = 4'h7;
        `LSBM_SIZE_HALF: m = 4'h3;
        default: m = 4'h1;
      endcase
      m = m << a;
      f_lanes = big ? {m[0], m[1], m[2], m[3]} : m;
    end
  endfunction

  function [2:0] f_md_kind;
    input [31:0] w;
    begin
      f_md_kind = `LSBM_MD_NONE;
      if (w[31:26] == `LSBM_OP_SPECIAL) begin
        case (w[5:0])
          `LSBM_FN_MULT, `LSBM_FN_MULTU: f_md_kind = `LSBM_MD_ACC;
          `LSBM_FN_DIV, `LSBM_FN_UNSIGNED_DIVIDE: f_md_kind = `LSBM_MD_DIV;
          `LSBM_FN_READ_HIGH, `LSBM_FN_READ_LOW: f_md_kind = `LSBM_MD_READ;
          default: f_md_kind = `LSBM_MD_NONE;
        endcase
      end else if (w[31:26] == `LSBM_OP_SPECIAL2) begin
        case (w[5:0])
          `LSBM_FN2_MADD, `LSBM_FN2_MADDU, `LSBM_FN2_MSUB, `LSBM_FN2_MSUBU:
            f_md_kind = `LSBM_MD_ACC;
          `LSBM_FN2_MUL_GPR: f_md_kind = `LSBM_MD_GPR;
          `LSBM_FN2_CLZ, `LSBM_FN2_CLO: f_md_kind = `LSBM_MD_COUNT;
          default: f_md_kind = `LSBM_MD_NONE;
        endcase
      end
    end
  endfunction

  function f_short;
    input [31:0] v;
    begin
      f_short = (v[31:15] == 17'h00000) || (v[31:15] == 17'h1FFFF);
    end
  endfunction

  function [5:0] f_dec;
    input [5:0] v;
    begin
      f_dec = (v == 6'h00) ? 6'h00 : v - 6'h01;
    end
  endfunction

  function [5:0] f_max;
    input [5:0] a;
    input [5:0] b;
    begin
      f_max = (a > b) ? a : b;
    end
  endfunction

  function [5:0] f_lead;
    input [31:0] v;
    input ones;
    integer k;
    reg done;
    begin
      f_lead = 6'h00;
      done = 1'b0;
      for (k = 31; k >= 0; k = k - 1) begin
        if (!done && v[k] == ones) begin
          f_lead = f_lead + 6'h01;
        end else begin
          done = 1'b1;
        end
      end
    end
  endfunction

  reg [31:0] ins_q, pc_q, rs_q, rt_q;
  reg pend_q, null_q;
  reg [5:0] wait_q, lat_q, rep_q;

  wire take = i_instr_valid & o_ready;
  wire exec_now = pend_q & (wait_q == 6'h00);
  wire bad_fetch = (pc_q[1:0] != `LSBM_INSTR_ALIGN_MASK); // see [RULE1]
  wire eff = exec_now & ~null_q & ~bad_fetch;

  wire [5:0] h_op = ins_q[31:26];
  wire [5:0] h_fn = ins_q[5:0];
  wire [4:0] h_rt = ins_q[20:16];
  wire [2:0] h_kind = f_md_kind(ins_q);
  wire h_short = f_short(rs_q) & f_short(rt_q);
  wire [31:0] slot_pc = pc_q + 32'h00000004;
  wire [31:0] sext_imm = {{16{ins_q[15]}}, ins_q[15:0]};

  wire [31:0] ea = rs_q + sext_imm; // see [RULE3] [RULE5]
  wire [1:0] h_size = f_size(ins_q); // see [RULE6]
  wire h_mem = f_is_load(ins_q) | f_is_store(ins_q);

  wire rs_zero = (rs_q == 32'h00000000);
  wire is_regimm = (h_op == `LSBM_OP_REGIMM) & (h_rt[3:2] == 2'h0);
  wire is_cmp_br = (h_op[5:3] == 3'h0 && h_op[2] == 1'b1) || (h_op[5:2] == 4'h5);
  wire is_branch = is_regimm | is_cmp_br;
  wire is_likely = is_regimm ? h_rt[1] : h_op[4];
  reg br_taken;
  always @* begin
    case (h_op[1:0])
      2'h0: br_taken = (rs_q == rt_q);
      2'h1: br_taken = (rs_q != rt_q);
      2'h2: br_taken = rs_q[31] | rs_zero;
      default: br_taken = ~rs_q[31] & ~rs_zero;
    endcase
    if (is_regimm) begin
      br_taken = h_rt[0] ? ~rs_q[31] : rs_q[31];
    end
  end
  wire is_jdir = (h_op == `LSBM_OP_JUMP) | (h_op == `LSBM_OP_JUMP_LINK);
  wire is_jreg = (h_op == `LSBM_OP_SPECIAL) &
                 ((h_fn == `LSBM_FN_REG_JUMP) | (h_fn == `LSBM_FN_REG_JUMP_LINK));
  wire is_link = (h_op == `LSBM_OP_JUMP_LINK) | (is_regimm & h_rt[4]) |
                 (is_jreg & (h_fn == `LSBM_FN_REG_JUMP_LINK));

  reg [31:0] tgt;
  always @* begin
    if (is_jdir) begin
      tgt = {slot_pc[31:28], ins_q[25:0], 2'h0}; // see [RULE15]
    end else if (is_jreg) begin
      tgt = rs_q; // see [RULE16]
    end else begin
      tgt = slot_pc + {sext_imm[29:0], 2'h0}; // see [RULE17]
    end
  end

  // next-cycle muldiv timers; a new operation reloads them as it executes
  wire md_go = eff & ((h_kind == `LSBM_MD_ACC) | (h_kind == `LSBM_MD_GPR) |
                      (h_kind == `LSBM_MD_DIV));
  wire is_div = (h_kind == `LSBM_MD_DIV);
  wire [5:0] lat_d = md_go ? (is_div ? `LSBM_DIV_CYCLES : // see [RULE12]
                     (h_short ? `LSBM_LAT_SHORT : `LSBM_LAT_LONG)) : f_dec(lat_q); // see [RULE10]
  wire [5:0] rep_d = md_go ? (is_div ? `LSBM_DIV_CYCLES :
                     (h_short ? `LSBM_REP_SHORT : `LSBM_REP_LONG)) : f_dec(rep_q); // see [RULE10]
  wire [5:0] post = (eff & (h_kind == `LSBM_MD_GPR)) ?
                    (h_short ? `LSBM_STALL_SHORT : `LSBM_STALL_LONG) : 6'h00; // see [RULE11]

  // the instruction executing now is the one right before the one being taken
  wire [2:0] n_kind = f_md_kind(i_instr);
  wire n_md = (n_kind == `LSBM_MD_ACC) | (n_kind == `LSBM_MD_GPR) | (n_kind == `LSBM_MD_DIV);
  wire load_use = eff & f_is_load(ins_q) & (h_rt != 5'h00) &
                  ((i_instr[25:21] == h_rt) | (i_instr[20:16] == h_rt));
  wire [5:0] w_load = load_use ? `LSBM_LOAD_USE_WAIT : 6'h00; // see [RULE4]
  wire [5:0] w_read = (n_kind == `LSBM_MD_READ) ? f_dec(lat_d) : 6'h00; // see [RULE9]
  wire [5:0] w_rep = n_md ? f_dec(rep_d) : 6'h00;
  // count ops stay out of the muldiv timers; they wait only on a load-use or multiply-to-register stall
  wire [5:0] new_wait = f_max(f_max(w_load, post), f_max(w_read, w_rep)); // see [RULE13]

  wire pend_d = take | (pend_q & ~exec_now);
  wire [5:0] wait_d = take ? new_wait : f_dec(wait_q);

  always @(posedge i_mclk) begin
    if (i_srst) begin
      ins_q <= 32'h00000000;
      pc_q <= 32'h00000000;
      rs_q <= 32'h00000000;
      rt_q <= 32'h00000000;
      pend_q <= 1'b0;
      null_q <= 1'b0;
      wait_q <= 6'h00;
      lat_q <= 6'h00;
      rep_q <= 6'h00;
      o_ready <= 1'b0;
    end else begin
      if (take) begin
        ins_q <= i_instr;
        pc_q <= i_pc;
        rs_q <= i_rs_val;
        rt_q <= i_rt_val;
      end
      pend_q <= pend_d;
      wait_q <= wait_d;
      lat_q <= lat_d;
      rep_q <= rep_d;
      o_ready <= ~(pend_d & (wait_d != 6'h00));
      if (eff & is_branch & is_likely & ~br_taken) begin
        null_q <= 1'b1; // see [RULE18]
      end else if (exec_now) begin
        null_q <= 1'b0;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_exec <= 1'b0;
      o_exec_pc <= 32'h00000000;
      o_format <= `LSBM_FMT_IMM;
      o_fetch_err <= 1'b0;
      o_nullified <= 1'b0;
      o_mem_valid <= 1'b0;
      o_mem_store <= 1'b0;
      o_mem_addr <= 32'h00000000;
      o_mem_size <= `LSBM_SIZE_BYTE;
      o_mem_lanes <= 4'h0;
      o_addr_err <= 1'b0;
      o_redirect <= 1'b0;
      o_target <= 32'h00000000;
      o_link_we <= 1'b0;
      o_link_reg <= 5'h00;
      o_link_data <= 32'h00000000;
      o_md_start <= 1'b0;
      o_hilo_read <= 1'b0;
      o_hilo_sel_high <= 1'b0;
      o_count_valid <= 1'b0;
      o_count_value <= 6'h00;
    end else begin
      o_exec <= exec_now;
      o_fetch_err <= exec_now & bad_fetch; // see [RULE1]
      o_nullified <= exec_now & null_q; // see [RULE18]
      if (exec_now) begin
        o_exec_pc <= pc_q;
        o_format <= f_format(ins_q); // see [RULE2]
        o_mem_addr <= ea;
        o_mem_size <= h_size;
        o_mem_lanes <= f_lanes(h_size, ea[1:0], i_big_endian); // see [RULE8]
        o_target <= tgt;
        o_link_reg <= (is_jreg) ? ins_q[15:11] : `LSBM_LINK_REG;
        o_link_data <= slot_pc + 32'h00000004; // see [RULE19]
        o_hilo_sel_high <= (h_fn == `LSBM_FN_READ_HIGH);
        o_count_value <= f_lead(rs_q, h_fn[0]); // see [RULE13]
      end
      o_mem_valid <= eff & h_mem & f_addr_ok(h_size, ea[1:0]);
      o_mem_store <= eff & f_is_store(ins_q);
      o_addr_err <= eff & h_mem & ~f_addr_ok(h_size, ea[1:0]); // see [RULE7]
      // the delay slot comes from the fetcher as the next taken instruction
      o_redirect <= eff & (is_jdir | is_jreg | (is_branch & br_taken)); // see [RULE14]
      o_link_we <= eff & is_link; // see [RULE19]
      o_md_start <= md_go;
      o_hilo_read <= eff & (h_kind == `LSBM_MD_READ);
      o_count_valid <= eff & (h_kind == `LSBM_MD_COUNT);
    end
  end

endmodule

// *** lsbm_chk.sv ***
module lsbm_chk (
  input wire i_mclk,
  input wire i_srst,
  input wire o_ready,
  input wire o_exec,
  input wire [31:0] o_exec_pc,
  input wire [1:0] o_format,
  input wire o_fetch_err,
  input wire o_nullified,
  input wire o_mem_valid,
  input wire [31:0] o_mem_addr,
  input wire [1:0] o_mem_size,
  input wire [3:0] o_mem_lanes,
  input wire o_addr_err,
  input wire o_redirect,
  input wire [31:0] o_target,
  input wire o_link_we,
  input wire [31:0] o_link_data,
  input wire o_md_start,
  input wire o_count_valid,
  input wire [5:0] o_count_value
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [31:0] pc_p4 = o_exec_pc + 32'h4;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  AST_RST: assert property (disable iff (1'b0) i_srst |=> !o_ready && !o_exec)
    else $error("activity after reset");
  AST_FETCH: assert property (o_fetch_err |-> o_exec_pc[1:0] != 2'h0 && !o_mem_valid)
    else $error("fetch error wrong");
  AST_FMT: assert property (o_exec |-> o_format != 2'h3)
    else $error("bad format");
  AST_WORD: assert property (o_mem_valid && o_mem_size == 2'h3 |-> o_mem_addr[1:0] == 2'h0)
    else $error("unaligned word");
  AST_HALF: assert property (o_mem_valid && o_mem_size == 2'h1 |-> !o_mem_addr[0])
    else $error("odd halfword");
  AST_AERR: assert property (o_addr_err |-> o_exec && !o_mem_valid)
    else $error("address error with access");
  AST_LANES: assert property (o_mem_valid |-> $countones(o_mem_lanes) == o_mem_size + 1)
    else $error("lane count");
  AST_NULL: assert property (o_nullified |-> !(o_mem_valid || o_redirect || o_md_start))
    else $error("nullified slot had effect");
  AST_LINK: assert property (o_link_we |-> o_link_data == o_exec_pc + 32'h8)
    else $error("link value");
  AST_JMP: assert property (o_redirect && o_format == 2'h1 |-> o_target[31:28] == pc_p4[31:28])
    else $error("jump region");
  AST_MDREP: assert property (o_md_start |=> !o_md_start)
    else $error("muldiv reissued too soon");
  AST_CNT: assert property (o_count_valid |-> o_count_value <= 6'h20)
    else $error("count range");
endmodule
bind lsbm_core lsbm_chk lsbm_chk_inst (.*);

// *** tb_lsbm_core.sv ***
module tb_lsbm_core;
  timeunit 1ns;
  timeprecision 1ps;
  reg i_mclk = 0, i_srst = 1, i_instr_valid = 0, i_big_endian = 0;
  reg [31:0] i_instr = 0, i_pc = 0, i_rs_val = 0, i_rt_val = 0;
  wire o_ready, o_exec, o_fetch_err, o_nullified, o_mem_valid, o_mem_store, o_addr_err;
  wire o_redirect, o_link_we, o_md_start, o_hilo_read, o_hilo_sel_high, o_count_valid;
  wire [31:0] o_exec_pc, o_mem_addr, o_target, o_link_data;
  wire [1:0] o_format, o_mem_size;
  wire [3:0] o_mem_lanes;
  wire [4:0] o_link_reg;
  wire [5:0] o_count_value;
  integer bad_count = 0, check_count = 0, cyc = 0, last_cyc = 0, gap = 0, n_exec = 0, base;
  reg [9:0] flg, pflg;
  reg [38:0] lk, plk;
  reg [31:0] tg, ptg;
  lsbm_core lsbm_core_inst (.*);
  always #12.5 i_mclk = ~i_mclk;
  // capture each executed instruction at the quiet edge
  always @(negedge i_mclk) begin
    cyc = cyc + 1;
    if (o_exec === 1'b1) begin
      gap = cyc - last_cyc;
      last_cyc = cyc;
      n_exec = n_exec + 1;
      pflg = flg;
      ptg = tg;
      plk = lk;
      tg = o_target;
      lk = {o_format, o_link_reg, o_link_data};
      flg = {o_mem_store, o_fetch_err, o_nullified, o_mem_valid, o_addr_err, o_redirect,
        o_link_we, o_md_start, o_hilo_read, o_count_valid};
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // called at a rising edge; returns at the edge that took the word
  task send(input [31:0] ins, input [31:0] pc, input [31:0] rs, input [31:0] rt, input keep);
    integer t;
    begin
      i_instr <= ins;
      i_pc <= pc;
      i_rs_val <= rs;
      i_rt_val <= rt;
      i_instr_valid <= 1'b1;
      t = 0;
      @(negedge i_mclk);
      while (o_ready !== 1'b1 && t < 100) begin
        @(negedge i_mclk);
        t = t + 1;
      end
      @(posedge i_mclk);
      if (!keep) i_instr_valid <= 1'b0;
    end
  endtask
  task wait_n(input integer k);
    integer t;
    begin
      t = 0;
      while (n_exec < base + k && t < 100) begin
        @(posedge i_mclk);
        t = t + 1;
      end
      chk(t < 100, 1);
    end
  endtask
  task t_access;
    integer s, a, b;
    reg [7:0] m;
    begin
      for (b = 0; b < 2; b = b + 1)
        for (s = 0; s < 4; s = s + 1)
          for (a = 0; a < 4; a = a + 1) begin
            i_big_endian <= b[0];
            base = n_exec;
            send({4'h8, s[1:0], 10'h22, 16'hFFF0 + a[15:0]}, 32'h100, 32'h2010, 0, 0);
            wait_n(1);
            m = ((8'h2 << s) - 8'h1) << a;
            if (b == 1) m = {4'h0, m[0], m[1], m[2], m[3]};
            if (a + s <= 3 && !(s == 1 && a == 1)) begin
              chk(flg, 9'h040);
              chk(o_mem_addr, 32'h2000 + a);
              chk(o_mem_size, s);
              chk(o_mem_lanes, m);
              chk(o_format, 0);
            end else chk(flg, 9'h020);
          end
    end
  endtask
  task t_fetch_load_use;
    begin
      base = n_exec;
      send(32'h8C220000, 32'h102, 32'h100, 0, 0);
      wait_n(1);
      chk(flg, 9'h100);
      base = n_exec;
      send(32'h8C250000, 32'h200, 32'h300, 0, 1);
      send(32'h00A63821, 32'h204, 1, 2, 0);
      wait_n(2);
      chk(gap, 2);
      chk(o_exec_pc, 32'h204);
      base = n_exec;
      send(32'hAC220004, 32'h208, 32'h300, 0, 0);
      wait_n(1);
      chk(flg, 10'h240);
      chk(o_mem_addr, 32'h304);
    end
  endtask
  task pair(input [31:0] i1, input [31:0] i2, input [31:0] v, input integer g);
    begin
      repeat (40) @(posedge i_mclk);
      base = n_exec;
      send(i1, 32'h400, v, v, 1);
      send(i2, 32'h404, v, v, 0);
      wait_n(2);
      chk(gap, g);
    end
  endtask
  task xfer(input [31:0] ins, input [31:0] pc, input [31:0] rs, input [31:0] rt,
    input [31:0] tgt, input [8:0] f, input [8:0] sf);
    begin
      base = n_exec;
      send(ins, pc, rs, rt, 1);
      send(32'h8C220000, pc + 32'h4, 32'h100, 0, 0);
      wait_n(2);
      chk(pflg, f);
      chk(flg, sf);
      if (f[4]) chk(ptg, tgt);
      if (f[3]) chk(plk[31:0], pc + 32'h8);
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    results;
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    t_access;
    t_fetch_load_use;
    pair(32'h00220018, 32'h00001812, 32'h12345, 4);
    chk(pflg, 9'h004);
    chk(flg, 9'h002);
    chk(o_hilo_sel_high, 0);
    chk(o_format, 2);
    pair(32'h00220019, 32'h00001810, 7, 3);
    chk(o_hilo_sel_high, 1);
    pair(32'h70220000, 32'h70220001, 32'h12345, 3);
    pair(32'h70220004, 32'h70220005, 7, 2);
    pair(32'h70221802, 32'h00A63821, 32'h12345, 3);
    pair(32'h70221802, 32'h00A63821, 7, 2);
    pair(32'h0022001A, 32'h00001812, 7, 36);
    pair(32'h0022001B, 32'h00220018, 32'h12345, 36);
    pair(32'h70231820, 32'h70231821, 32'hFFFF0000, 1);
    chk(pflg, 9'h001);
    chk(flg, 9'h001);
    chk(o_count_value, 16);
    xfer(32'h08000100, 32'h4FFFFFFC, 0, 0, 32'h50000400, 9'h010, 9'h040);
    chk(plk[38:37], 1);
    xfer(32'h0C000100, 32'h10, 0, 0, 32'h400, 9'h018, 9'h040);
    chk(plk[36:32], 5'h1F);
    xfer(32'h00200008, 32'h20, 32'hABCDE0, 0, 32'hABCDE0, 9'h010, 9'h040);
    chk(plk[38:37], 2);
    xfer(32'h00202009, 32'h30, 32'hABCDE0, 0, 32'hABCDE0, 9'h018, 9'h040);
    chk(plk[36:32], 5'h04);
    xfer(32'h1022FFFE, 32'h1000, 5, 5, 32'hFFC, 9'h010, 9'h040);
    chk(plk[38:37], 0);
    xfer(32'h1422FFFE, 32'h1000, 5, 5, 0, 9'h000, 9'h040);
    xfer(32'h5022FFFE, 32'h1000, 5, 6, 0, 9'h000, 9'h080);
    xfer(32'h54220004, 32'h2000, 5, 6, 32'h2014, 9'h010, 9'h040);
    xfer(32'h04310004, 32'h3000, 5, 0, 32'h3014, 9'h018, 9'h040);
    xfer(32'h04220004, 32'h3100, 5, 0, 0, 9'h000, 9'h080);
    results;
  end
endmodule
